/* File: rtl/acs_pkg.sv */
// Constants shared by the converter sequencer, its serial shifter and its result FIFO.
// Assumes a 125 MHz system clock; master clock and serial clock arrive as pins.
package acs_pkg;

  // ---------------------------------------------------------------
  // Sequencing counts, in master clock cycles
  // ---------------------------------------------------------------
  localparam int unsigned WAKE_CYC = 1800;
  localparam int unsigned CAL_CYC = 3246;
  localparam int unsigned CONVERT_REQUEST_FIRST_CYC = 1624;
  localparam int unsigned CONVERT_REQUEST_CONT_CYC = 1622;
  localparam int unsigned CAL_OFFSET_CYC = CAL_CYC / 2;

  // ---------------------------------------------------------------
  // Power-on delay, in system clock cycles
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ = 125;
  localparam int unsigned POR_TIME_MS = 10;
  localparam int unsigned POR_CYC = POR_TIME_MS * 1000 * SYS_CLK_MHZ;

  // ---------------------------------------------------------------
  // Result word
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam logic [15:0] BIPOLAR_OFS = 16'h8000;
  localparam int unsigned FIFO_DEPTH = 16;

  // Count width for the longest sequencing interval
  localparam int unsigned MCNT_W = 12;

  typedef enum logic [2:0] {
    ACS_POR, ACS_WAKE, ACS_STBY, ACS_CAL_OFS, ACS_CAL_GAIN, ACS_CONVERT_REQUEST
  } acs_state_e;

endpackage

/* File: rtl/acs_fifo.sv */
// Result FIFO between the conversion engine and the serial shifter.
// Assumes both sides run on the system clock.
`timescale 1ns/1ps
module acs_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  assign o_in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_r != rd_r;
  assign o_out_data = mem[rd_r[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_r - rd_r) <= (AW+1)'(DEPTH)) else $error("fifo level over depth");
endmodule

/* File: rtl/acs_shifter.sv */
// Serial shifter: loads one word when chip select is taken, shifts on serial clock falls.
// Assumes chip select and serial clock are already synchronised to the system clock.
`timescale 1ns/1ps
module acs_shifter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_cs_act,
  input wire logic i_sclk_rise,
  input wire logic i_sclk_fall,
  input wire logic i_word_valid,
  input wire logic [WIDTH-1:0] i_word,
  output logic o_word_take,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_busy
);
  localparam int unsigned BW = $clog2(WIDTH + 1);

  typedef struct packed {
    logic [WIDTH-1:0] sh;
    logic [BW-1:0] left;
    logic armed;
    logic busy;
    logic oe;
  } acs_sh_s;

  acs_sh_s q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    o_word_take = 1'b0;
    if (!q_r.busy) begin
      if (i_cs_act && i_word_valid) begin
        q_nxt.sh = i_word;
        q_nxt.left = BW'(WIDTH);
        q_nxt.busy = 1'b1;
        q_nxt.armed = 1'b0;
        q_nxt.oe = 1'b1;
        o_word_take = 1'b1;
      end
    end else begin
      if (i_sclk_rise) begin
        q_nxt.armed = 1'b1;
      end
      if (i_sclk_fall && q_r.armed) begin
        q_nxt.sh = {q_r.sh[WIDTH-2:0], 1'b0};
        q_nxt.left = q_r.left - 1'b1;
        if (q_r.left == BW'(1) || !i_cs_act) begin
          q_nxt.busy = 1'b0;
          q_nxt.oe = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign o_sdo = q_r.sh[WIDTH-1];
  assign o_sdo_oe = q_r.oe;
  assign o_busy = q_r.busy;

  sh_unarmed_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (q_r.busy && !q_r.armed && !i_sclk_rise) |=> $stable(q_r.left))
    else $error("shift before rising edge");
endmodule

/* File: rtl/acs_sequencer.sv */
// Converter control sequencer: power-on delay, wake-up, standby, two-phase
// calibration, conversion timing and serial read-out of the result word.
// Assumes master clock, command pins, chip select and serial clock are
// asynchronous pins; the filtered sample arrives as a plain word input.
`timescale 1ns/1ps

// How it works
// - After reset, all logic is held idle for about 10 ms.
// - Wake-up then lasts 1800 master clock cycles before any state.
// - Commands seen at power-on or during wake-up run after wake-up.
// - No pending command at end of wake-up gives standby.
// - Calibrate and convert both high enter calibration; from standby at once.
// - Calibration runs an offset phase first, then a gain phase.
// - Calibration takes 3246 master cycles; coefficients are kept for conversions.
// - Bipolar results add 8000H to the calibrated word; same coefficients.
// - Polarity select is ignored during calibration.
// - At calibration end, convert high starts conversion, low gives standby.
// - Dropping calibrate request does not disturb a running calibration.
// - Convert low-high with calibrate high restarts calibration.
// - Convert low-high with calibrate low during calibration is ignored.
// - A convert command starts a filter cycle; output updates after it.
// - Serial data advances on each falling serial clock edge.
// - Falling edges count only after a rising edge arms the shifter.
// - Chip select released early: finish current bit, then float output.
// - Chip select is not taken while result-ready is high in the last cycles.
// - A conversion from standby takes 1624 master cycles to result-ready.
// - Back-to-back conversions take 1622 master cycles each.
// - A convert rising edge mid-conversion restarts the conversion.
module acs_sequencer #(
  parameter int unsigned POR_CYCLES = acs_pkg::POR_CYC,
  parameter int unsigned WAKE_CYCLES = acs_pkg::WAKE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_master_clock_in,
  input wire logic i_cal_request,
  input wire logic i_convert_request,
  input wire logic i_polarity_select,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [15:0] i_filter_word,
  input wire logic [15:0] i_cal_zero,
  output logic o_result_ready_n,
  output logic o_shift_data_out,
  output logic o_shift_data_oe,
  output logic o_calibrating,
  output logic o_cal_valid,
  output logic o_fifo_full
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [5:0] s3_r;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      s3_r <= 6'h00;
    end else begin
      s1_r <= {i_master_clock_in, i_cal_request, i_convert_request,
               i_polarity_select, ~i_cs_n, i_sclk};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  logic mclk_tick;
  logic cal_q;
  logic convert_request_q;
  logic convert_request_rise;
  logic pol_q;
  logic cs_q;
  logic sclk_rise;
  logic sclk_fall;
  assign mclk_tick = s2_r[5] && !s3_r[5];
  assign cal_q = s2_r[4];
  assign convert_request_q = s2_r[3];
  assign convert_request_rise = s2_r[3] && !s3_r[3];
  assign pol_q = s2_r[2];
  assign cs_q = s2_r[1];
  assign sclk_rise = s2_r[0] && !s3_r[0];
  assign sclk_fall = !s2_r[0] && s3_r[0];

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  typedef struct packed {
    acs_pkg::acs_state_e st;
    logic [26:0] por;
    logic [acs_pkg::MCNT_W-1:0] cnt;
    logic first;
    logic cal_pend;
    logic convert_request_pend;
    logic [15:0] zero;
    logic cal_ok;
    logic [15:0] res;
    logic res_vld;
    logic rdy_n;
    logic [1:0] late;
  } acs_seq_s;

  acs_seq_s q_r, q_nxt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic word_take;
  logic sh_busy;
  logic sh_sdo;
  logic sh_oe;
  logic cs_ok;

  function automatic logic [15:0] acs_code(input logic [15:0] raw, input logic [15:0] zero,
                                           input logic bip);
    logic [15:0] c;
    c = raw - zero;
    acs_code = bip ? (c ^ acs_pkg::BIPOLAR_OFS) : c;
  endfunction

  always_comb begin
    q_nxt = q_r;
    q_nxt.res_vld = 1'b0;
    if (fifo_in_ready) begin
      q_nxt.rdy_n = 1'b1;
    end
    unique case (q_r.st)
      acs_pkg::ACS_POR: begin
        q_nxt.por = q_r.por + 27'(1);
        if (q_r.por == 27'(POR_CYCLES - 1)) begin
          q_nxt.st = acs_pkg::ACS_WAKE;
          q_nxt.cnt = '0;
        end
      end
      acs_pkg::ACS_WAKE: begin
        if (cal_q && convert_request_q) begin
          q_nxt.cal_pend = 1'b1;
        end
        if (convert_request_q) begin
          q_nxt.convert_request_pend = 1'b1;
        end
        if (mclk_tick) begin
          q_nxt.cnt = q_r.cnt + 1'b1;
          if (q_r.cnt == acs_pkg::MCNT_W'(WAKE_CYCLES - 1)) begin
            q_nxt.cnt = '0;
            q_nxt.first = 1'b1;
            if (q_r.cal_pend || (cal_q && convert_request_q)) begin
              q_nxt.st = acs_pkg::ACS_CAL_OFS;
            end else if (q_r.convert_request_pend || convert_request_q) begin
              q_nxt.st = acs_pkg::ACS_CONVERT_REQUEST;
            end else begin
              q_nxt.st = acs_pkg::ACS_STBY;
            end
          end
        end
      end
      acs_pkg::ACS_STBY: begin
        q_nxt.cnt = '0;
        q_nxt.first = 1'b1;
        if (cal_q && convert_request_q) begin
          q_nxt.st = acs_pkg::ACS_CAL_OFS;
        end else if (convert_request_rise) begin
          q_nxt.st = acs_pkg::ACS_CONVERT_REQUEST;
        end
      end
      acs_pkg::ACS_CAL_OFS, acs_pkg::ACS_CAL_GAIN: begin
        // Polarity is not consulted anywhere in these states
        if (mclk_tick) begin
          q_nxt.cnt = q_r.cnt + 1'b1;
          if (q_r.cnt == acs_pkg::MCNT_W'(acs_pkg::CAL_OFFSET_CYC - 1)) begin
            q_nxt.st = acs_pkg::ACS_CAL_GAIN;
            q_nxt.zero = i_cal_zero;
          end
          if (q_r.cnt == acs_pkg::MCNT_W'(acs_pkg::CAL_CYC - 1)) begin
            q_nxt.cal_ok = 1'b1;
            q_nxt.cnt = '0;
            q_nxt.first = 1'b1;
            q_nxt.st = convert_request_q ? acs_pkg::ACS_CONVERT_REQUEST : acs_pkg::ACS_STBY;
          end
        end
        if (convert_request_rise && cal_q) begin
          q_nxt.st = acs_pkg::ACS_CAL_OFS;
          q_nxt.cnt = '0;
        end
      end
      acs_pkg::ACS_CONVERT_REQUEST: begin
        if (convert_request_rise) begin
          q_nxt.cnt = '0;
          q_nxt.first = 1'b1;
        end else if (mclk_tick) begin
          q_nxt.cnt = q_r.cnt + 1'b1;
          if (q_r.cnt == (q_r.first ? acs_pkg::MCNT_W'(acs_pkg::CONVERT_REQUEST_FIRST_CYC - 1)
                                    : acs_pkg::MCNT_W'(acs_pkg::CONVERT_REQUEST_CONT_CYC - 1))) begin
            q_nxt.cnt = '0;
            q_nxt.first = 1'b0;
            q_nxt.res = acs_code(i_filter_word, q_r.zero, pol_q);
            q_nxt.res_vld = 1'b1;
            q_nxt.rdy_n = 1'b0;
            q_nxt.late = 2'h0;
            if (!convert_request_q) begin
              q_nxt.st = acs_pkg::ACS_STBY;
            end
          end
        end
        if (cal_q && convert_request_q) begin
          q_nxt.st = acs_pkg::ACS_CAL_OFS;
          q_nxt.cnt = '0;
        end
      end
      default: begin
        q_nxt.st = acs_pkg::ACS_STBY;
      end
    endcase
    // Result-ready high for two master cycles blocks new chip select;
    // a word waiting in the FIFO keeps result-ready low and chip select open
    if (!q_r.rdy_n || fifo_out_valid) begin
      q_nxt.late = 2'h0;
    end else if (mclk_tick && q_r.late != 2'h2) begin
      q_nxt.late = q_r.late + 2'h1;
    end
  end

  assign cs_ok = cs_q && (sh_busy || q_r.late != 2'h2 || !q_r.rdy_n);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q_r <= '0;
      q_r.st <= acs_pkg::ACS_POR;
      q_r.rdy_n <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Result path
  // ---------------------------------------------------------------
  acs_fifo #(.WIDTH(acs_pkg::WORD_W), .DEPTH(acs_pkg::FIFO_DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_in_valid(q_r.res_vld),
    .i_in_data(q_r.res),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(word_take)
  );

  acs_shifter #(.WIDTH(acs_pkg::WORD_W)) u_shift (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_cs_act(cs_ok),
    .i_sclk_rise(sclk_rise),
    .i_sclk_fall(sclk_fall),
    .i_word_valid(fifo_out_valid),
    .i_word(fifo_out_data),
    .o_word_take(word_take),
    .o_sdo(sh_sdo),
    .o_sdo_oe(sh_oe),
    .o_busy(sh_busy)
  );

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_result_ready_n <= 1'b1;
      o_shift_data_out <= 1'b0;
      o_shift_data_oe <= 1'b0;
      o_calibrating <= 1'b0;
      o_cal_valid <= 1'b0;
      o_fifo_full <= 1'b0;
    end else begin
      o_result_ready_n <= q_r.rdy_n && !fifo_out_valid;
      o_shift_data_out <= sh_sdo;
      o_shift_data_oe <= sh_oe;
      o_calibrating <= (q_r.st == acs_pkg::ACS_CAL_OFS) || (q_r.st == acs_pkg::ACS_CAL_GAIN);
      o_cal_valid <= q_r.cal_ok;
      o_fifo_full <= !fifo_in_ready;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence cal_enter_s;
    (q_r.st == acs_pkg::ACS_STBY) && cal_q && convert_request_q;
  endsequence

  cal_start_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cal_enter_s |=> (q_r.st == acs_pkg::ACS_CAL_OFS)) else $error("no calibration start");
  por_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (q_r.st == acs_pkg::ACS_POR) |-> o_result_ready_n && !o_shift_data_oe)
    else $error("activity during power-on");
  cal_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (q_r.st == acs_pkg::ACS_CAL_GAIN && !(convert_request_rise && cal_q))
    |=> (q_r.st != acs_pkg::ACS_CAL_OFS))
    else $error("phase order broken");
  cal_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (q_r.st == acs_pkg::ACS_CAL_OFS && !cal_q && !mclk_tick) |=> $stable(q_r.cnt))
    else $error("calibration disturbed");
  cal_ign_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ((q_r.st inside {acs_pkg::ACS_CAL_OFS, acs_pkg::ACS_CAL_GAIN}) && convert_request_rise && !cal_q
     && q_r.cnt != acs_pkg::MCNT_W'(acs_pkg::CAL_CYC - 1))
    |=> (q_r.st inside {acs_pkg::ACS_CAL_OFS, acs_pkg::ACS_CAL_GAIN})
        && (q_r.cnt >= $past(q_r.cnt))) else $error("convert not ignored");
  cal_restart_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ((q_r.st inside {acs_pkg::ACS_CAL_OFS, acs_pkg::ACS_CAL_GAIN}) && convert_request_rise && cal_q)
    |=> (q_r.st == acs_pkg::ACS_CAL_OFS && q_r.cnt == '0)) else $error("no restart");
  cal_end_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (q_r.st == acs_pkg::ACS_CAL_GAIN && mclk_tick && !convert_request_rise
     && q_r.cnt == acs_pkg::MCNT_W'(acs_pkg::CAL_CYC - 1))
    |=> q_r.cal_ok && (q_r.st == ($past(convert_request_q) ? acs_pkg::ACS_CONVERT_REQUEST : acs_pkg::ACS_STBY)))
    else $error("calibration end wrong");
  convert_request_restart_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (q_r.st == acs_pkg::ACS_CONVERT_REQUEST && convert_request_rise && !cal_q) |=> (q_r.cnt == '0 && q_r.first))
    else $error("conversion not restarted");
  res_bip_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    q_r.res_vld |-> !q_r.rdy_n && (q_r.res == (($past(i_filter_word) - $past(q_r.zero))
                                  ^ ($past(pol_q) ? acs_pkg::BIPOLAR_OFS : 16'h0000))))
    else $error("result code wrong");

  // Wake-up end: a remembered calibration wins, nothing pending gives standby
  sequence wake_end_s;
    (q_r.st == acs_pkg::ACS_WAKE) && mclk_tick
      && (q_r.cnt == acs_pkg::MCNT_W'(WAKE_CYCLES - 1));
  endsequence

  wake_cmd_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wake_end_s ##0 q_r.cal_pend |=> (q_r.st == acs_pkg::ACS_CAL_OFS))
    else $error("pending calibration lost");
  wake_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wake_end_s ##0 (!q_r.cal_pend && !q_r.convert_request_pend && !convert_request_q)
    |=> (q_r.st == acs_pkg::ACS_STBY)) else $error("no standby after wake-up");
  coef_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !(q_r.st inside {acs_pkg::ACS_CAL_OFS, acs_pkg::ACS_CAL_GAIN}) |=> $stable(q_r.zero))
    else $error("coefficient changed outside calibration");
  ready_src_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_result_ready_n) |-> $past(q_r.res_vld) || $past(fifo_out_valid))
    else $error("result-ready without a result");
  float_end_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_shift_data_oe) |-> $past(sclk_fall, 2)) else $error("output floated off a fall");
endmodule

/* File: verification/acs_host_model.sv */
// Host side of the serial read-out: drives chip select and the serial clock.
// Assumes the 125 MHz system clock of the bench; serial period is 64 ns.
`timescale 1ns/1ps
module acs_host_model (
  input wire logic i_sys_clk,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_cs_n,
  output logic o_sclk
);
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  // Serial clock stands still low between frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
  end

  // ---------------------------------------------------------------
  // Frame
  // ---------------------------------------------------------------
  // Bits are sampled late in the high phase, well after the previous fall
  task automatic read_word(input int nbits, output logic [15:0] word,
                           output logic oe_seen, output logic oe_after);
    word = 16'h0000;
    oe_seen = 1'b1;
    @(negedge i_sys_clk);
    o_cs_n <= 1'b0;
    repeat (34) @(negedge i_sys_clk);
    for (int i = 0; i < nbits; i++) begin
      o_sclk <= 1'b1;
      repeat (3) @(negedge i_sys_clk);
      word[15-i] = i_sdo;
      oe_seen = oe_seen & i_sdo_oe;
      // Early release lands inside the bit that is still in progress
      if (nbits < 16 && i == nbits - 1) begin
        o_cs_n <= 1'b1;
      end
      @(negedge i_sys_clk);
      o_sclk <= 1'b0;
      repeat (4) @(negedge i_sys_clk);
    end
    repeat (8) @(negedge i_sys_clk);
    oe_after = i_sdo_oe;
    o_cs_n <= 1'b1;
    @(negedge i_sys_clk);
  endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the converter sequencer with a queue-based result model.
// Assumes a shortened power-on delay and wake-up; master clock 32 ns, unrelated phase.
`timescale 1ns/1ps
module testbench;
  localparam int unsigned POR_SIM = 50;
  localparam int unsigned WAKE_SIM = 20;
  logic i_sys_clk, i_rst, mclk, cal, convert_request, pol;
  logic [15:0] filt, zero, z_cal, lfsr, w;
  logic cs_n, sclk, sdo, sdo_oe, rdy_n, calib, cal_ok, full, oe1, oe2;
  int errors, total_checks, cyc, ticks, mark, r;
  logic [15:0] exp_q[$];

  // ---------------------------------------------------------------
  // Clocks, design and host
  // ---------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    mclk = 1'b0;
    #3;
    forever #16 mclk = ~mclk;
  end
  always @(posedge mclk) ticks = ticks + 1;
  always @(posedge i_sys_clk) begin
    cyc = cyc + 1;
    // Whole run needs about 70k cycles
    if (cyc == 90000) begin
      errors++;
      end_sim();
    end
  end

  acs_sequencer #(.POR_CYCLES(POR_SIM), .WAKE_CYCLES(WAKE_SIM)) u_dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_master_clock_in(mclk),
    .i_cal_request(cal), .i_convert_request(convert_request), .i_polarity_select(pol),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_filter_word(filt), .i_cal_zero(zero),
    .o_result_ready_n(rdy_n), .o_shift_data_out(sdo), .o_shift_data_oe(sdo_oe),
    .o_calibrating(calib), .o_cal_valid(cal_ok), .o_fifo_full(full));
  acs_host_model u_host (.i_sys_clk(i_sys_clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
    .o_cs_n(cs_n), .o_sclk(sclk));

  // ---------------------------------------------------------------
  // Model and checking helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] model_word(input logic [15:0] f, input logic [15:0] z,
                                             input logic b);
    return (f - z) ^ (b ? acs_pkg::BIPOLAR_OFS : 16'h0000);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input int v, input int lo, input int hi);
    total_checks++;
    if (v < lo || v > hi) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask
  task automatic to_tick(input int t);
    while (ticks < t) @(negedge i_sys_clk);
  endtask
  // Bounded wait on calibrating (sel 1) or result-ready (sel 0)
  task automatic wait_sig(input bit sel, input logic v);
    int n;
    n = 0;
    while (((sel ? calib : rdy_n) !== v) && n < 40000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 40000) chk({15'h0000, ~v}, {15'h0000, v});
  endtask
  task automatic read_chk(input int nbits);
    logic [15:0] e, m;
    e = exp_q.pop_front();
    m = 16'hFFFF << (16 - nbits);
    u_host.read_word(nbits, w, oe1, oe2);
    chk(w & m, e & m);
    chk({15'h0000, oe1}, 16'h0001);
    chk({15'h0000, oe2}, 16'h0000);
  endtask
  task automatic new_sample(input logic b);
    lfsr = lfsr_next(lfsr);
    filt = lfsr;
    pol = b;
    exp_q.push_back(model_word(filt, z_cal, b));
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    {cal, convert_request, pol} = 3'b000;
    {errors, total_checks, cyc, ticks} = '0;
    lfsr = 16'h001C;
    filt = 16'h0000;
    zero = 16'h0000;
    repeat (10) @(negedge i_sys_clk);
    chk({13'h0000, rdy_n, sdo_oe, calib}, 16'h0004);
    i_rst = 1'b0;
    mark = cyc;
    lfsr = lfsr_next(lfsr);
    filt = lfsr;
    zero = ~lfsr;
    // Command given during the power-on delay waits for the end of wake-up
    cal = 1'b1;
    convert_request = 1'b1;
    repeat (40) @(negedge i_sys_clk);
    chk({15'h0000, calib}, 16'h0000);
    wait_sig(1'b1, 1'b1);
    chk_win(cyc - mark, POR_SIM + WAKE_SIM * 4 - 4, POR_SIM + WAKE_SIM * 4 + 20);
    mark = ticks;
    to_tick(mark + 10);
    cal = 1'b0;
    // Zero point must be taken at the end of the offset phase only
    to_tick(mark + 800);
    lfsr = lfsr_next(lfsr);
    zero = lfsr;
    z_cal = lfsr;
    pol = 1'b1;
    to_tick(mark + 2400);
    zero = ~z_cal;
    pol = 1'b0;
    new_sample(1'b0);
    wait_sig(1'b1, 1'b0);
    chk_win(ticks - mark, 3245, 3247);
    chk({15'h0000, cal_ok}, 16'h0001);
    mark = ticks;
    wait_sig(1'b0, 1'b0);
    chk_win(ticks - mark, 1623, 1626);
    // Back to back, polarity switched just after result-ready falls
    mark = ticks;
    new_sample(1'b1);
    read_chk(16);
    wait_sig(1'b0, 1'b0);
    chk_win(ticks - mark, 1621, 1623);
    mark = ticks;
    new_sample(1'b0);
    read_chk(16);
    to_tick(mark + 500);
    convert_request = 1'b0;
    to_tick(mark + 505);
    convert_request = 1'b1;
    mark = ticks;
    wait_sig(1'b0, 1'b0);
    chk_win(ticks - mark, 1623, 1626);
    read_chk(5);
    // Calibration restarts and an ignored convert command
    mark = ticks;
    cal = 1'b1;
    wait_sig(1'b1, 1'b1);
    chk_win(ticks - mark, 0, 3);
    mark = ticks;
    to_tick(mark + 10);
    cal = 1'b0;
    to_tick(mark + 300);
    convert_request = 1'b0;
    to_tick(mark + 305);
    convert_request = 1'b1;
    to_tick(mark + 320);
    chk({15'h0000, calib}, 16'h0001);
    to_tick(mark + 1000);
    cal = 1'b1;
    to_tick(mark + 1002);
    convert_request = 1'b0;
    to_tick(mark + 1006);
    convert_request = 1'b1;
    r = ticks;
    to_tick(mark + 1010);
    cal = 1'b0;
    to_tick(mark + 1020);
    convert_request = 1'b0;
    wait_sig(1'b1, 1'b0);
    chk_win(ticks - r, 3245, 3248);
    to_tick(ticks + 1800);
    chk({14'h0000, rdy_n, full}, 16'h0002);
    // Zero point comes from the restarted calibration; later input changes are ignored
    z_cal = zero;
    zero = ~zero;
    // Single convert pulse from standby
    new_sample(1'b1);
    convert_request = 1'b1;
    mark = ticks;
    to_tick(mark + 20);
    convert_request = 1'b0;
    wait_sig(1'b0, 1'b0);
    chk_win(ticks - mark, 1623, 1626);
    read_chk(16);
    // Reset again in mid-run with no command pending: wake-up must end in standby
    i_rst = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (POR_SIM + WAKE_SIM * 4 + 40) @(negedge i_sys_clk);
    chk({12'h000, rdy_n, calib, cal_ok, full}, 16'h0008);
    end_sim();
  end
endmodule
